// >>> rtl/parity_status.v
// Data memory parity error status bank with an AHB-Lite register slave.
// Assumes one clock, a synchronous active-low reset, parity checkers that
// raise one bit per subbank (pulse or level) and a single AHB-Lite master.
//
// How it works
// R1 - Memory 0 banks 3:2 register at F46D
// R2 - Bits 12:8 flag memory 0 bank 3
// R3 - Bits 4:0 flag memory 0 bank 2
// R4 - Memory 1 banks 1:0 register at F46E
// R5 - Bits 12:8 bank 1, 4:0 bank 0
// R6 - Memory 1 banks 3:2 register at F46F
// R7 - Bits 12:8 bank 3, 4:0 bank 2
// R8 - Flags read-only, every status register resets to zero
// R9 - Checker sets its flag; writes leave flags
`timescale 1ns/100ps
`include "parity_status_defines.vh"

module parity_status
(
    // Clock and reset
    input wire i_ref_clk,
    input wire i_rstn,
    // AHB-Lite slave
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire [31:0] i_hwdata,
    input wire i_hready,
    output reg o_hreadyout,
    output reg o_hresp,
    output reg [31:0] o_hrdata,
    // Parity checker error strobes, one bit per subbank
    input wire [4:0] i_mem0_bank3_fault,
    input wire [4:0] i_mem0_bank2_fault,
    input wire [4:0] i_mem1_bank1_fault,
    input wire [4:0] i_mem1_bank0_fault,
    input wire [4:0] i_mem1_bank3_fault,
    input wire [4:0] i_mem1_bank2_fault,
    // Interrupt
    output reg o_irq
);

    // Bus states
    localparam S_IDLE = 2'b01;
    localparam S_RDWAIT = 2'b10;

    // Byte addresses of the registers
    localparam [31:0] ADDR_DM0_UPPER = {`ADDR_HIGH_PAD, `IDX_DM0_UPPER, `ADDR_LOW_PAD};
    localparam [31:0] ADDR_DM1_LOWER = {`ADDR_HIGH_PAD, `IDX_DM1_LOWER, `ADDR_LOW_PAD};
    localparam [31:0] ADDR_DM1_UPPER = {`ADDR_HIGH_PAD, `IDX_DM1_UPPER, `ADDR_LOW_PAD};
    localparam [31:0] ADDR_IRQ_STATUS = {`ADDR_HIGH_PAD, `IDX_IRQ_STATUS, `ADDR_LOW_PAD};
    localparam [31:0] ADDR_IRQ_MASK = {`ADDR_HIGH_PAD, `IDX_IRQ_MASK, `ADDR_LOW_PAD};

    // Select vector positions
    localparam SEL_DM0_UPPER = 0;
    localparam SEL_DM1_LOWER = 1;
    localparam SEL_DM1_UPPER = 2;
    localparam SEL_IRQ_STATUS = 3;
    localparam SEL_IRQ_MASK = 4;
    localparam SEL_W = 5;

    // Sticky error flags
    reg [`SUB_COUNT-1:0] mem0_bank3_fault;
    reg [`SUB_COUNT-1:0] mem0_bank2_fault;
    reg [`SUB_COUNT-1:0] mem1_bank1_fault;
    reg [`SUB_COUNT-1:0] mem1_bank0_fault;
    reg [`SUB_COUNT-1:0] mem1_bank3_fault;
    reg [`SUB_COUNT-1:0] mem1_bank2_fault;

    // Reserved bits are plain read/write storage
    reg [`REG_W-1:0] dm0_upper_spare;
    reg [`REG_W-1:0] dm1_lower_spare;
    reg [`REG_W-1:0] dm1_upper_spare;

    // Interrupt registers
    reg [`IRQ_BITS-1:0] irq_status;
    reg [`IRQ_BITS-1:0] irq_mask;

    // Bus state
    reg [1:0] state;
    reg [1:0] next_state;
    reg wr_pending;
    reg [SEL_W-1:0] wr_sel;
    reg [SEL_W-1:0] rd_sel;

    // Combinational helpers
    wire accept;
    wire [SEL_W-1:0] addr_sel;
    wire [SEL_W-1:0] wr_hit;
    wire [`IRQ_BITS-1:0] events;
    wire [`IRQ_BITS-1:0] irq_clear;
    wire [`IRQ_BITS-1:0] next_irq_status;
    wire [`REG_W-1:0] dm0_upper_parity_errors;
    wire [`REG_W-1:0] dm1_lower_parity_errors;
    wire [`REG_W-1:0] dm1_upper_parity_errors;
    reg [31:0] next_rdata;

    // One-hot register select for a byte address; unmapped gives zero
    function [SEL_W-1:0] decode;
        input [31:0] addr;
        begin
            decode = {SEL_W{1'b0}};
            decode[SEL_DM0_UPPER] = (addr == ADDR_DM0_UPPER);
            decode[SEL_DM1_LOWER] = (addr == ADDR_DM1_LOWER);
            decode[SEL_DM1_UPPER] = (addr == ADDR_DM1_UPPER);
            decode[SEL_IRQ_STATUS] = (addr == ADDR_IRQ_STATUS);
            decode[SEL_IRQ_MASK] = (addr == ADDR_IRQ_MASK);
        end
    endfunction

    // Builds a status word from its two subbank fields and spare bits
    function [`REG_W-1:0] pack_word;
        input [`SUB_COUNT-1:0] hi_field;
        input [`SUB_COUNT-1:0] lo_field;
        input [`REG_W-1:0] spare;
        begin
            pack_word = (spare & `RESERVED_MASK)
                      | ({`FIELD_PAD, hi_field} << `HI_FIELD_LSB)
                      | ({`FIELD_PAD, lo_field} << `LO_FIELD_LSB);
        end
    endfunction

    // True when a strobe hits a subbank whose flag is still clear
    function fresh_error;
        input [`SUB_COUNT-1:0] flags;
        input [`SUB_COUNT-1:0] strobes;
        begin
            fresh_error = |(strobes & ~flags);
        end
    endfunction

    // A transfer is taken only with hready high at its address phase
    assign accept = i_hsel & i_htrans[`HTRANS_ACTIVE_BIT] & i_hready;
    assign addr_sel = decode(i_haddr);
    assign wr_hit = wr_pending ? wr_sel : {SEL_W{1'b0}};

    assign dm0_upper_parity_errors = pack_word(mem0_bank3_fault, mem0_bank2_fault, dm0_upper_spare); // R1 R2 R3
    assign dm1_lower_parity_errors = pack_word(mem1_bank1_fault, mem1_bank0_fault, dm1_lower_spare); // R4 R5
    assign dm1_upper_parity_errors = pack_word(mem1_bank3_fault, mem1_bank2_fault, dm1_upper_spare); // R6 R7

    // A new error, not a repeat on an already flagged subbank, raises an event
    assign events[`IRQ_DM0_UPPER] = fresh_error(mem0_bank3_fault, i_mem0_bank3_fault)
                                  | fresh_error(mem0_bank2_fault, i_mem0_bank2_fault);
    assign events[`IRQ_DM1_LOWER] = fresh_error(mem1_bank1_fault, i_mem1_bank1_fault)
                                  | fresh_error(mem1_bank0_fault, i_mem1_bank0_fault);
    assign events[`IRQ_DM1_UPPER] = fresh_error(mem1_bank3_fault, i_mem1_bank3_fault)
                                  | fresh_error(mem1_bank2_fault, i_mem1_bank2_fault);

    // Write one to clear; an event in the same cycle wins over the clear
    assign irq_clear = wr_hit[SEL_IRQ_STATUS] ? i_hwdata[`IRQ_BITS-1:0] : `IRQ_RESET;
    assign next_irq_status = (irq_status & ~irq_clear) | events;

    // Error flags: set only by the checkers, cleared only by reset
    always @(posedge i_ref_clk)
    begin
        if (!i_rstn)
        begin
            mem0_bank3_fault <= `FLAG_RESET; // R8
            mem0_bank2_fault <= `FLAG_RESET; // R8
            mem1_bank1_fault <= `FLAG_RESET; // R8
            mem1_bank0_fault <= `FLAG_RESET; // R8
            mem1_bank3_fault <= `FLAG_RESET; // R8
            mem1_bank2_fault <= `FLAG_RESET; // R8
        end
        else
        begin
            mem0_bank3_fault <= mem0_bank3_fault | i_mem0_bank3_fault; // R2 R9
            mem0_bank2_fault <= mem0_bank2_fault | i_mem0_bank2_fault; // R3 R9
            mem1_bank1_fault <= mem1_bank1_fault | i_mem1_bank1_fault; // R5 R9
            mem1_bank0_fault <= mem1_bank0_fault | i_mem1_bank0_fault; // R5 R9
            mem1_bank3_fault <= mem1_bank3_fault | i_mem1_bank3_fault; // R7 R9
            mem1_bank2_fault <= mem1_bank2_fault | i_mem1_bank2_fault; // R7 R9
        end
    end

    // Spare bits take bus writes; the flag positions are masked off
    always @(posedge i_ref_clk)
    begin
        if (!i_rstn)
        begin
            dm0_upper_spare <= `REG_RESET; // R8
            dm1_lower_spare <= `REG_RESET; // R8
            dm1_upper_spare <= `REG_RESET; // R8
        end
        else
        begin
            if (wr_hit[SEL_DM0_UPPER])
            begin
                dm0_upper_spare <= i_hwdata[`REG_W-1:0] & `RESERVED_MASK; // R9
            end
            if (wr_hit[SEL_DM1_LOWER])
            begin
                dm1_lower_spare <= i_hwdata[`REG_W-1:0] & `RESERVED_MASK; // R9
            end
            if (wr_hit[SEL_DM1_UPPER])
            begin
                dm1_upper_spare <= i_hwdata[`REG_W-1:0] & `RESERVED_MASK; // R9
            end
        end
    end

    // Interrupt status, mask and output
    always @(posedge i_ref_clk)
    begin
        if (!i_rstn)
        begin
            irq_status <= `IRQ_RESET;
            irq_mask <= `IRQ_RESET;
            o_irq <= 1'b0;
        end
        else
        begin
            irq_status <= next_irq_status;
            if (wr_hit[SEL_IRQ_MASK])
            begin
                irq_mask <= i_hwdata[`IRQ_BITS-1:0];
            end
            // Registered from current state, so it trails the status by one cycle
            o_irq <= |(irq_status & irq_mask);
        end
    end

    // Read data is muxed a cycle after the address phase so that a write
    // in its data phase at that time is already visible
    always @*
    begin
        next_rdata = `RDATA_RESET;
        case (1'b1)
            rd_sel[SEL_DM0_UPPER]: next_rdata = {`REG_PAD, dm0_upper_parity_errors}; // R1
            rd_sel[SEL_DM1_LOWER]: next_rdata = {`REG_PAD, dm1_lower_parity_errors}; // R4
            rd_sel[SEL_DM1_UPPER]: next_rdata = {`REG_PAD, dm1_upper_parity_errors}; // R6
            rd_sel[SEL_IRQ_STATUS]: next_rdata = {`IRQ_PAD, irq_status};
            rd_sel[SEL_IRQ_MASK]: next_rdata = {`IRQ_PAD, irq_mask};
            default: next_rdata = `RDATA_RESET;
        endcase
    end

    always @*
    begin
        next_state = state;
        case (state)
            S_IDLE:
            begin
                if (accept && !i_hwrite)
                begin
                    next_state = S_RDWAIT;
                end
            end
            S_RDWAIT:
            begin
                next_state = S_IDLE;
            end
            default:
            begin
                next_state = S_IDLE;
            end
        endcase
    end

    // Bus slave: writes have no wait state, reads one
    always @(posedge i_ref_clk)
    begin
        if (!i_rstn)
        begin
            state <= S_IDLE;
            wr_pending <= 1'b0;
            wr_sel <= {SEL_W{1'b0}};
            rd_sel <= {SEL_W{1'b0}};
            o_hreadyout <= 1'b1;
            o_hresp <= `HRESP_OKAY;
            o_hrdata <= `RDATA_RESET;
        end
        else
        begin
            state <= next_state;
            o_hresp <= `HRESP_OKAY;
            wr_pending <= 1'b0;
            case (state)
                S_IDLE:
                begin
                    o_hreadyout <= 1'b1;
                    if (accept)
                    begin
                        if (i_hwrite)
                        begin
                            wr_pending <= 1'b1;
                            wr_sel <= addr_sel;
                        end
                        else
                        begin
                            rd_sel <= addr_sel;
                            o_hreadyout <= 1'b0;
                        end
                    end
                end
                S_RDWAIT:
                begin
                    o_hrdata <= next_rdata;
                    o_hreadyout <= 1'b1;
                end
                default:
                begin
                    o_hreadyout <= 1'b1;
                end
            endcase
        end
    end

endmodule // parity_status

// >>> rtl/parity_status_defines.vh
// Constants for the data memory parity error status bank.
// Included by the bank's module; holds definitions only.
`ifndef PARITY_STATUS_DEFINES_VH
`define PARITY_STATUS_DEFINES_VH

// Register indices; the byte address is four times the index
`define IDX_DM0_UPPER 16'hF46D
`define IDX_DM1_LOWER 16'hF46E
`define IDX_DM1_UPPER 16'hF46F
`define IDX_IRQ_STATUS 16'hF478
`define IDX_IRQ_MASK 16'hF479
`define IDX_W 16
`define ADDR_HIGH_PAD 14'h0000
`define ADDR_LOW_PAD 2'h0

// Register layout
`define REG_W 16
`define SUB_COUNT 5
`define HI_FIELD_LSB 8
`define LO_FIELD_LSB 0
`define FIELD_PAD 11'h000
`define RESERVED_MASK 16'hE0E0
`define FLAG_RESET 5'h00
`define REG_RESET 16'h0000
`define REG_PAD 16'h0000

// Interrupt layout, one event bit per status register
`define IRQ_BITS 3
`define IRQ_DM0_UPPER 0
`define IRQ_DM1_LOWER 1
`define IRQ_DM1_UPPER 2
`define IRQ_RESET 3'h0
`define IRQ_PAD 29'h00000000

// Bus encodings
`define HTRANS_ACTIVE_BIT 1
`define HRESP_OKAY 1'b0
`define RDATA_RESET 32'h00000000

`endif

// >>> testbench/parity_status_assertions.sv
// Checker for the parity status bank, bound to the bank's ports.
// Assumes one clock and the bank's one-wait-state AHB-Lite reads.
`timescale 1ns/100ps
`include "parity_status_defines.vh"

module parity_status_checker
(
    // Clock, reset and bus
    input logic i_ref_clk, i_rstn, i_hsel, i_hwrite, i_hready, o_hreadyout, o_hresp, o_irq,
    input logic [31:0] i_haddr, i_hwdata, o_hrdata,
    input logic [1:0] i_htrans,
    input logic [2:0] i_hsize,
    // Parity checker strobes
    input logic [4:0] i_mem0_bank3_fault, i_mem0_bank2_fault, i_mem1_bank1_fault,
    input logic [4:0] i_mem1_bank0_fault, i_mem1_bank3_fault, i_mem1_bank2_fault
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    logic [4:0] seen_a;
    logic [4:0] seen_b;
    wire rd = i_hsel && i_htrans[1] && i_hready && !i_hwrite;
    wire wr = i_hsel && i_htrans[1] && i_hready && i_hwrite;
    wire hit = i_haddr[31:18] == `ADDR_HIGH_PAD && i_haddr[1:0] == `ADDR_LOW_PAD && i_haddr[17:2] inside
        {`IDX_DM0_UPPER, `IDX_DM1_LOWER, `IDX_DM1_UPPER, `IDX_IRQ_STATUS, `IDX_IRQ_MASK};
    // Sticky reference of what the strobes should have left in two fields
    always_ff @(posedge i_ref_clk)
    begin
        seen_a <= i_rstn ? seen_a | i_mem0_bank3_fault : 5'h00;
        seen_b <= i_rstn ? seen_b | i_mem1_bank2_fault : 5'h00;
    end
    property p_okay; o_hresp == `HRESP_OKAY; endproperty
    property p_reset; disable iff (1'b0) !i_rstn |=> o_hreadyout && !o_irq && o_hrdata == 32'h00000000; endproperty
    property p_rd_wait; rd |=> !o_hreadyout ##1 o_hreadyout; endproperty
    property p_wr_nowait; wr |=> o_hreadyout; endproperty
    property p_low_one; !o_hreadyout |=> o_hreadyout; endproperty
    property p_upper_zero; rd |-> ##2 o_hrdata[31:16] == 16'h0000; endproperty
    property p_unmapped; rd && !hit |-> ##2 o_hrdata == 32'h00000000; endproperty
    // Index alone is not enough: the bank decodes the full address, so stray high bits read as unmapped
    property p_dm0_b3; rd && hit && i_haddr[17:2] == `IDX_DM0_UPPER |-> ##2 o_hrdata[12:8] == $past(seen_a); endproperty
    property p_dm1_b2; rd && hit && i_haddr[17:2] == `IDX_DM1_UPPER |-> ##2 o_hrdata[4:0] == $past(seen_b); endproperty
    a_okay: assert property (p_okay) else $error("response not OKAY");
    a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
    a_low_one: assert property (p_low_one) else $error("ready low too long");
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_dm0_b3: assert property (p_dm0_b3) else $error("memory 0 bank 3 flags wrong");
    a_dm1_b2: assert property (p_dm1_b2) else $error("memory 1 bank 2 flags wrong");
    c_read: cover property (rd);
    c_write: cover property (wr);
    c_irq: cover property ($rose(o_irq));
endmodule // parity_status_checker

bind parity_status parity_status_checker parity_status_checker_inst (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .i_hsel(i_hsel), .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_irq(o_irq), .i_haddr(i_haddr), .i_hwdata(i_hwdata), .o_hrdata(o_hrdata), .i_htrans(i_htrans),
    .i_hsize(i_hsize), .i_mem0_bank3_fault(i_mem0_bank3_fault), .i_mem0_bank2_fault(i_mem0_bank2_fault),
    .i_mem1_bank1_fault(i_mem1_bank1_fault), .i_mem1_bank0_fault(i_mem1_bank0_fault),
    .i_mem1_bank3_fault(i_mem1_bank3_fault), .i_mem1_bank2_fault(i_mem1_bank2_fault));

// >>> testbench/parity_status_tb.sv
// Self-checking bench for the parity status bank over AHB-Lite.
// Assumes hready is the bank's own hreadyout and word transfers only.
`timescale 1ns/100ps
`include "parity_status_defines.vh"

module parity_status_tb;
    logic i_ref_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_hsel = 1'b0;
    logic i_hwrite = 1'b0;
    logic [1:0] i_htrans = 2'h0;
    logic [31:0] i_haddr = 32'h00000000;
    logic [31:0] i_hwdata = 32'h00000000;
    logic [4:0] flt [0:5] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00};
    logic [4:0] acc [0:5];
    logic [15:0] idx [0:2] = '{`IDX_DM0_UPPER, `IDX_DM1_LOWER, `IDX_DM1_UPPER};
    logic [15:0] rsv;
    logic [31:0] expq [$];
    logic [31:0] rng = 32'h3125;
    logic [31:0] r32;
    logic rd_ph = 1'b0;
    wire o_hreadyout, o_hresp, o_irq;
    wire [31:0] o_hrdata;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;

    always #10 i_ref_clk = ~i_ref_clk;

    parity_status parity_status_inst (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_hsel(i_hsel),
        .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
        .i_hready(o_hreadyout), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
        .i_mem0_bank3_fault(flt[0]), .i_mem0_bank2_fault(flt[1]), .i_mem1_bank1_fault(flt[2]),
        .i_mem1_bank0_fault(flt[3]), .i_mem1_bank3_fault(flt[4]), .i_mem1_bank2_fault(flt[5]), .o_irq(o_irq));

    function logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    function logic [31:0] pv(int r);
        return {16'h0000, rsv[15:13], acc[2*r], rsv[7:5], acc[2*r+1]};
    endfunction

    task check(string name, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task print_verdict;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Holds each phase until hready is sampled high; a read notes its expectation
    task xfer(input logic w, input logic [15:0] ix, input logic [31:0] d);
        i_hsel <= 1'b1;
        i_htrans <= 2'h2;
        i_hwrite <= w;
        i_haddr <= {`ADDR_HIGH_PAD, ix, `ADDR_LOW_PAD};
        if (!w)
            expq.push_back(d);
        do @(posedge i_ref_clk); while (o_hreadyout !== 1'b1);
        i_hsel <= 1'b0;
        i_htrans <= 2'h0;
        i_hwdata <= w ? d : 32'h00000000;
        do @(posedge i_ref_clk); while (o_hreadyout !== 1'b1);
    endtask

    task pulse(input int g, input logic [4:0] v);
        flt[g] <= v;
        acc[g] = acc[g] | v;
        @(posedge i_ref_clk);
        flt[g] <= 5'h00;
    endtask

    task rd_all;
        for (int r = 0; r < 3; r++)
            xfer(1'b0, idx[r], pv(r));
    endtask

    always @(posedge i_ref_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            bad_count++;
            print_verdict();
        end
        else
        begin
            if (rd_ph && o_hreadyout === 1'b1)
                check("hrdata", o_hrdata, expq.pop_front());
            if (o_hreadyout === 1'b1)
                rd_ph <= i_hsel && i_htrans[1] && !i_hwrite;
        end
    end

    initial
    begin
        acc = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00};
        rsv = 16'h0000;
        repeat (20) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        rd_all();
        xfer(1'b0, `IDX_IRQ_STATUS, 32'h0);
        xfer(1'b0, `IDX_IRQ_MASK, 32'h0);
        xfer(1'b1, 16'hF470, 32'hFFFFFFFF);
        xfer(1'b0, 16'hF470, 32'h0);
        $display("test 1 done");
        // Flag bits ignore writes while the spare bits keep what was written
        for (int r = 0; r < 3; r++)
            xfer(1'b1, idx[r], 32'h0000FFFF);
        rsv = 16'hE0E0;
        rd_all();
        $display("test 2 done");
        r32 = xs();
        pulse(0, r32[4:0] | 5'h01);
        r32 = xs();
        pulse(1, r32[4:0]);
        repeat (3) @(posedge i_ref_clk);
        check("irq masked", o_irq, 32'h0);
        xfer(1'b0, `IDX_IRQ_STATUS, 32'h1);
        xfer(1'b1, `IDX_IRQ_MASK, 32'h7);
        repeat (3) @(posedge i_ref_clk);
        check("irq raised", o_irq, 32'h1);
        xfer(1'b1, `IDX_IRQ_STATUS, 32'h1);
        repeat (3) @(posedge i_ref_clk);
        check("irq cleared", o_irq, 32'h0);
        // A repeated error on a flag already set raises no new event
        pulse(0, acc[0]);
        repeat (3) @(posedge i_ref_clk);
        check("irq repeat", o_irq, 32'h0);
        xfer(1'b0, `IDX_IRQ_STATUS, 32'h0);
        rd_all();
        $display("test 3 done");
        for (int g = 2; g < 6; g++)
        begin
            r32 = xs();
            pulse(g, r32[4:0] | 5'h10);
        end
        rd_all();
        xfer(1'b0, `IDX_IRQ_STATUS, 32'h6);
        check("irq memory 1", o_irq, 32'h1);
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        acc = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00};
        rsv = 16'h0000;
        rd_all();
        xfer(1'b0, `IDX_IRQ_MASK, 32'h0);
        check("irq after reset", o_irq, 32'h0);
        $display("test 4 done");
        print_verdict();
    end
endmodule // parity_status_tb
